// ==== rtl/pss_pkg.sv ====
// constants shared by the parameter-set sequencer and its helper modules
// assumes a single clk_sys_i domain at 50 MHz; software uses a plain strobe port
package pss_pkg;
	// register word offsets on the plain register port
	localparam logic [3:0] REG_CTRL      = 4'h0;
	localparam logic [3:0] REG_TOTAL     = 4'h1;
	localparam logic [3:0] REG_CMD       = 4'h2;
	localparam logic [3:0] REG_STATUS    = 4'h3;
	localparam logic [3:0] REG_IRQ_STAT  = 4'h4;
	localparam logic [3:0] REG_IRQ_MASK  = 4'h5;
	localparam logic [3:0] REG_SET_IDX   = 4'h6;
	localparam logic [3:0] REG_SET_DATA  = 4'h7;
	localparam logic [3:0] REG_BASE      = 4'h8;
	localparam logic [3:0] REG_ACTIVE    = 4'h9;
	// field positions
	localparam int CTRL_ON_BIT     = 0;
	localparam int CMD_STEP_BIT    = 0;
	localparam int CMD_REWIND_BIT  = 1;
	localparam int ST_WAIT_BIT     = 0;
	localparam int ST_ACTIVE_BIT   = 1;
	localparam int ST_STEP_BIT     = 2;
	localparam int ST_REWIND_BIT   = 3;
	localparam int ST_EXPOSE_BIT   = 4;
	localparam int ST_XMIT_BIT     = 5;
	localparam int ST_IDX_LSB      = 8;
	// interrupt event bits
	localparam int IRQ_LOADED_BIT  = 0;
	localparam int IRQ_FRAME_BIT   = 1;
	localparam int IRQ_IGNORED_BIT = 2;
	localparam int IRQ_WRAP_BIT    = 3;
	localparam int IRQ_W           = 4;
	// reset values
	localparam logic [6:0] TOTAL_RST = 7'h01;
	localparam logic [3:0] MASK_RST  = 4'h0;
	// timing counts in clk_sys_i cycles, then set store depth and parameter width
	localparam int LOAD_CYCLES  = 4;
	localparam int EXPO_CYCLES  = 16;
	localparam int XMIT_CYCLES  = 16;
	localparam int MAX_SETS     = 64;
	localparam int PARAM_W      = 16;
	typedef enum logic [1:0] {
		PSS_WAIT,
		PSS_LOAD,
		PSS_FRAME
	} pss_state_e;
endpackage : pss_pkg

// ==== rtl/pss_set_store.sv ====
// storage for the parameter sets, written by software, read during set loading
// assumes rd_idx_i is held while a load runs; read data lag the index by one cycle
`timescale 1ns/100ps
module pss_set_store #(
	parameter int DEPTH = pss_pkg::MAX_SETS,
	parameter int PW    = pss_pkg::PARAM_W,
	parameter int IW    = $clog2(DEPTH)
) (
	input  wire logic          clk_sys_i,
	input  wire logic          ce_i,
	input  wire logic          wr_i,
	input  wire logic [IW-1:0] wr_idx_i,
	input  wire logic [PW-1:0] wr_data_i,
	input  wire logic [IW-1:0] rd_idx_i,
	output logic      [PW-1:0] rd_data_o
);
	logic [PW-1:0] mem_q [DEPTH];

	// no reset on the array: unstored sets simply hold whatever was last written
	always_ff @(posedge clk_sys_i)
	begin
		if (ce_i && wr_i)
		begin
			mem_q[wr_idx_i] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (ce_i)
		begin
			rd_data_o <= mem_q[rd_idx_i];
		end
	end
endmodule : pss_set_store

// ==== rtl/pss_frame_timer.sv ====
// one frame: exposure and readout, then transmission, started by an accepted trigger
// assumes start_i only arrives while idle
`timescale 1ns/100ps
module pss_frame_timer #(
	parameter int EXPO = pss_pkg::EXPO_CYCLES,
	parameter int XMIT = pss_pkg::XMIT_CYCLES
) (
	input  wire logic clk_sys_i,
	input  wire logic resetn_i,
	input  wire logic ce_i,
	input  wire logic start_i,
	output logic      expose_o,
	output logic      xmit_o,
	output logic      done_o
);
	localparam int CW = $clog2(EXPO + XMIT + 1);
	logic [CW-1:0] cnt_q;

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cnt_q    <= '0;
			expose_o <= 1'b0;
			xmit_o   <= 1'b0;
			done_o   <= 1'b0;
		end
		else if (ce_i)
		begin
			done_o <= 1'b0;
			if (start_i && !expose_o && !xmit_o)
			begin
				cnt_q    <= CW'(EXPO - 1);
				expose_o <= 1'b1;
			end
			else if (cnt_q != '0)
			begin
				cnt_q <= cnt_q - 1'b1;
			end
			else if (expose_o)
			begin
				expose_o <= 1'b0;
				xmit_o   <= 1'b1;
				cnt_q    <= CW'(XMIT - 1);
			end
			else if (xmit_o)
			begin
				xmit_o <= 1'b0;
				done_o <= 1'b1;
			end
		end
	end
endmodule : pss_frame_timer

// ==== rtl/pss_seq_top.sv ====
// parameter-set sequencer, controlled advance with software-only step and rewind
// assumes triggers and register strobes are synchronous to clk_sys_i
`timescale 1ns/100ps
module pss_seq_top #(
	parameter int NSETS = pss_pkg::MAX_SETS,
	parameter int PW    = pss_pkg::PARAM_W,
	parameter int LOADN = pss_pkg::LOAD_CYCLES,
	parameter int EXPO  = pss_pkg::EXPO_CYCLES,
	parameter int XMIT  = pss_pkg::XMIT_CYCLES
) (
	input  wire logic          clk_sys_i,
	input  wire logic          resetn_i,
	input  wire logic          ce_i,
	input  wire logic [3:0]    addr_i,
	input  wire logic [31:0]   wdata_i,
	input  wire logic          wr_i,
	input  wire logic          rd_i,
	output logic      [31:0]   rdata_o,
	input  wire logic          trig_i,
	output logic               waiting_o,
	output logic      [PW-1:0] active_param_o,
	output logic      [5:0]    active_index_o,
	output logic               expose_o,
	output logic               xmit_o,
	output logic               irq_o
);
	localparam int IW = 6;
	localparam int LW = $clog2(LOADN + 1);

	pss_pkg::pss_state_e state_q;
	pss_pkg::pss_state_e state_d;
	logic                   sequencer_on_q;
	logic [6:0]             total_q;
	logic [IW-1:0]          set_sel_q;
	logic [PW-1:0]          base_q;
	logic                   seq_active_q;
	logic                   step_pend_q;
	logic                   rewind_pend_q;
	logic [IW-1:0]          load_idx_q;
	logic [LW-1:0]          load_cnt_q;
	logic [pss_pkg::IRQ_W-1:0] irq_stat_q;
	logic [pss_pkg::IRQ_W-1:0] irq_mask_q;
	logic [PW-1:0]          store_rd;
	logic                   frm_done;
	logic                   wr_data;
	logic                   deferred_step_command;
	logic                   deferred_rewind_command;
	logic                   go_enable;
	logic                   go_rewind;
	logic                   go_step;
	logic                   go_restore;
	logic                   trig_take;
	logic                   load_end;
	logic [pss_pkg::IRQ_W-1:0] irq_evt;

	function automatic logic [IW-1:0] next_idx(input logic [IW-1:0] idx,
		input logic [6:0] total);
		logic [6:0] nxt;
		nxt = {1'b0, idx} + 7'h01;
		next_idx = (nxt >= total) ? '0 : nxt[IW-1:0];
	endfunction : next_idx

	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction : hit

	assign wr_data                 = wr_i && hit(addr_i, pss_pkg::REG_SET_DATA);
	assign deferred_step_command   = wr_i && hit(addr_i, pss_pkg::REG_CMD)
		&& wdata_i[pss_pkg::CMD_STEP_BIT];
	assign deferred_rewind_command = wr_i && hit(addr_i, pss_pkg::REG_CMD)
		&& wdata_i[pss_pkg::CMD_REWIND_BIT];

	// decisions are only taken while waiting, never during a load or a frame
	always_comb
	begin
		go_enable  = 1'b0;
		go_rewind  = 1'b0;
		go_step    = 1'b0;
		go_restore = 1'b0;
		trig_take  = 1'b0;
		if (state_q == pss_pkg::PSS_WAIT)
		begin
			if (sequencer_on_q && !seq_active_q)
				go_enable = 1'b1;
			else if (!sequencer_on_q && seq_active_q)
				go_restore = 1'b1;
			else if (seq_active_q && rewind_pend_q)
				go_rewind = 1'b1;
			else if (seq_active_q && step_pend_q)
				go_step = 1'b1;
			else
				trig_take = trig_i;
		end
	end

	assign load_end = (state_q == pss_pkg::PSS_LOAD) && (load_cnt_q == '0);

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			pss_pkg::PSS_WAIT:
			begin
				if (go_enable || go_rewind || go_step)
					state_d = pss_pkg::PSS_LOAD;
				else if (trig_take)
					state_d = pss_pkg::PSS_FRAME;
			end
			pss_pkg::PSS_LOAD:
			begin
				if (load_end)
					state_d = pss_pkg::PSS_WAIT;
			end
			pss_pkg::PSS_FRAME:
			begin
				if (frm_done)
					state_d = pss_pkg::PSS_WAIT;
			end
		endcase
	end

	// waiting is the registered image of the next state, so it drops with the load
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_q   <= pss_pkg::PSS_WAIT;
			waiting_o <= 1'b0;
		end
		else if (ce_i)
		begin
			state_q   <= state_d;
			waiting_o <= (state_d == pss_pkg::PSS_WAIT);
		end
	end

	// pending commands; an arrival in the consuming cycle stays pending
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			step_pend_q   <= 1'b0;
			rewind_pend_q <= 1'b0;
		end
		else if (ce_i)
		begin
			if (deferred_step_command && sequencer_on_q)
				step_pend_q <= 1'b1;
			else if (go_step || go_restore || go_enable)
				step_pend_q <= 1'b0;
			if (deferred_rewind_command && sequencer_on_q)
				rewind_pend_q <= 1'b1;
			else if (go_rewind || go_restore || go_enable)
				rewind_pend_q <= 1'b0;
		end
	end

	// set loading: index chosen at entry, the store output taken at the end
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			load_idx_q     <= '0;
			load_cnt_q     <= '0;
			active_index_o <= '0;
			active_param_o <= '0;
			seq_active_q   <= 1'b0;
		end
		else if (ce_i)
		begin
			if (go_enable || go_rewind)
			begin
				load_idx_q <= '0;
				load_cnt_q <= LW'(LOADN - 1);
			end
			else if (go_step)
			begin
				load_idx_q <= next_idx(active_index_o, total_q);
				load_cnt_q <= LW'(LOADN - 1);
			end
			else if (state_q == pss_pkg::PSS_LOAD && load_cnt_q != '0)
			begin
				load_cnt_q <= load_cnt_q - 1'b1;
			end
			if (go_enable)
				seq_active_q <= 1'b1;
			else if (go_restore)
				seq_active_q <= 1'b0;
			if (load_end)
			begin
				active_param_o <= store_rd;
				active_index_o <= load_idx_q;
			end
			else if (go_restore || (!seq_active_q && !sequencer_on_q))
			begin
				active_param_o <= base_q;
				active_index_o <= '0;
			end
		end
	end

	// register writes; base value is what the active set holds outside sequencing
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sequencer_on_q <= 1'b0;
			total_q        <= pss_pkg::TOTAL_RST;
			set_sel_q      <= '0;
			base_q         <= '0;
			irq_mask_q     <= pss_pkg::MASK_RST;
		end
		else if (ce_i && wr_i)
		begin
			if (hit(addr_i, pss_pkg::REG_CTRL))
				sequencer_on_q <= wdata_i[pss_pkg::CTRL_ON_BIT];
			if (hit(addr_i, pss_pkg::REG_TOTAL))
				total_q <= (wdata_i[6:0] == 7'h00 || wdata_i[6:0] > 7'(NSETS))
					? 7'h01 : wdata_i[6:0];
			if (hit(addr_i, pss_pkg::REG_SET_IDX))
				set_sel_q <= wdata_i[IW-1:0];
			if (hit(addr_i, pss_pkg::REG_BASE))
				base_q <= wdata_i[PW-1:0];
			if (hit(addr_i, pss_pkg::REG_IRQ_MASK))
				irq_mask_q <= wdata_i[pss_pkg::IRQ_W-1:0];
		end
	end

	always_comb
	begin
		irq_evt                           = '0;
		irq_evt[pss_pkg::IRQ_LOADED_BIT]  = load_end;
		irq_evt[pss_pkg::IRQ_FRAME_BIT]   = frm_done;
		irq_evt[pss_pkg::IRQ_IGNORED_BIT] = trig_i && state_q != pss_pkg::PSS_WAIT;
		irq_evt[pss_pkg::IRQ_WRAP_BIT]    = go_step
			&& next_idx(active_index_o, total_q) == '0;
	end

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			irq_stat_q <= '0;
			irq_o      <= 1'b0;
		end
		else if (ce_i)
		begin
			if (wr_i && hit(addr_i, pss_pkg::REG_IRQ_STAT))
				irq_stat_q <= (irq_stat_q & ~wdata_i[pss_pkg::IRQ_W-1:0]) | irq_evt;
			else
				irq_stat_q <= irq_stat_q | irq_evt;
			irq_o <= |(irq_stat_q & irq_mask_q);
		end
	end

	// read data stand for one cycle only, unmapped offsets read zero
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rdata_o <= '0;
		else if (ce_i)
		begin
			rdata_o <= '0;
			if (rd_i)
			begin
				unique case (addr_i)
					pss_pkg::REG_CTRL:     rdata_o <= {31'h0, sequencer_on_q};
					pss_pkg::REG_TOTAL:    rdata_o <= {25'h0, total_q};
					pss_pkg::REG_STATUS:
					begin
						rdata_o[pss_pkg::ST_WAIT_BIT]   <= waiting_o;
						rdata_o[pss_pkg::ST_ACTIVE_BIT] <= seq_active_q;
						rdata_o[pss_pkg::ST_STEP_BIT]   <= step_pend_q;
						rdata_o[pss_pkg::ST_REWIND_BIT] <= rewind_pend_q;
						rdata_o[pss_pkg::ST_EXPOSE_BIT] <= expose_o;
						rdata_o[pss_pkg::ST_XMIT_BIT]   <= xmit_o;
						rdata_o[pss_pkg::ST_IDX_LSB +: IW] <= active_index_o;
					end
					pss_pkg::REG_IRQ_STAT: rdata_o <= {28'h0, irq_stat_q};
					pss_pkg::REG_IRQ_MASK: rdata_o <= {28'h0, irq_mask_q};
					pss_pkg::REG_SET_IDX:  rdata_o <= {26'h0, set_sel_q};
					pss_pkg::REG_BASE:     rdata_o <= 32'(base_q);
					pss_pkg::REG_ACTIVE:   rdata_o <= 32'(active_param_o);
					default:               rdata_o <= '0;
				endcase
			end
		end
	end

	pss_set_store #(
		.DEPTH (NSETS),
		.PW    (PW),
		.IW    (IW)
	) u_store (
		.clk_sys_i (clk_sys_i),
		.ce_i      (ce_i),
		.wr_i      (wr_data),
		.wr_idx_i  (set_sel_q),
		.wr_data_i (wdata_i[PW-1:0]),
		.rd_idx_i  (load_idx_q),
		.rd_data_o (store_rd)
	);

	// the frame runs to its end even if the sequencer is switched off
	pss_frame_timer #(
		.EXPO (EXPO),
		.XMIT (XMIT)
	) u_frame (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.ce_i      (ce_i),
		.start_i   (ce_i && trig_take),
		.expose_o  (expose_o),
		.xmit_o    (xmit_o),
		.done_o    (frm_done)
	);

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	sequence s_enable;
		ce_i && go_enable;
	endsequence
	sequence s_step(logic [IW-1:0] from);
		ce_i && go_step ##1 load_idx_q == next_idx(from, total_q);
	endsequence

	load_no_wait_a: assert property (state_q == pss_pkg::PSS_LOAD |-> !waiting_o)
		else $error("waiting shown during set load");
	load_ignores_trig_a: assert property (ce_i && trig_i && state_q == pss_pkg::PSS_LOAD
		|=> state_q != pss_pkg::PSS_FRAME)
		else $error("trigger taken during set load");
	enable_set0_a: assert property (s_enable |=> state_q == pss_pkg::PSS_LOAD
		&& load_idx_q == '0)
		else $error("enable did not load set 0");
	step_next_a: assert property (ce_i && go_step |-> s_step(active_index_o))
		else $error("step did not select next index");
	rewind_set0_a: assert property (ce_i && go_rewind |=> load_idx_q == '0
		&& state_q == pss_pkg::PSS_LOAD)
		else $error("rewind did not load set 0");
	frame_stable_a: assert property (state_q == pss_pkg::PSS_FRAME
		|-> $stable(active_param_o))
		else $error("active set changed during frame");
	idle_no_load_a: assert property (ce_i && state_q == pss_pkg::PSS_WAIT && seq_active_q
		&& sequencer_on_q && !step_pend_q && !rewind_pend_q
		|=> state_q != pss_pkg::PSS_LOAD)
		else $error("set changed without a command");
	pend_held_a: assert property (ce_i && step_pend_q && state_q != pss_pkg::PSS_WAIT
		|=> step_pend_q)
		else $error("pending step lost outside waiting");
	restore_base_a: assert property (ce_i && go_restore
		|=> active_param_o == $past(base_q) && !seq_active_q)
		else $error("disable did not restore base value");
	frame_finish_a: assert property (ce_i && state_q == pss_pkg::PSS_FRAME && !frm_done
		|=> state_q == pss_pkg::PSS_FRAME)
		else $error("frame cut short");
	load_done_a: assert property (ce_i && load_end |=> active_param_o == $past(store_rd)
		&& waiting_o)
		else $error("load end did not update active set");
endmodule : pss_seq_top

// ==== testbench/pss_trig_source.sv ====
// frame trigger source standing in front of the sequencer
// assumes shot_i and rogue_i are one-cycle pulses from the bench on clk_sys_i
`timescale 1ns/100ps
module pss_trig_source (
	input  wire logic clk_sys_i,
	input  wire logic resetn_i,
	input  wire logic waiting_i,
	input  wire logic shot_i,
	input  wire logic rogue_i,
	output logic      trig_o
);
	logic armed_q;

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			armed_q <= 1'b0;
			trig_o  <= 1'b0;
		end
		else if (armed_q && waiting_i && !trig_o)
		begin
			// one cycle only: the trigger is level sampled, a held level would start more frames
			armed_q <= 1'b0;
			trig_o  <= 1'b1;
		end
		else
		begin
			armed_q <= armed_q | shot_i;
			// misuse only when the bench asks for it
			trig_o  <= rogue_i;
		end
	end
endmodule : pss_trig_source

// ==== testbench/pss_seq_top_bench.sv ====
// self-checking bench for pss_seq_top: register tasks, frame helpers, trigger source
// assumes the register map and timing counts held in pss_pkg
`timescale 1ns/100ps
module pss_seq_top_bench;
	localparam int          LOADN = pss_pkg::LOAD_CYCLES;
	localparam int          EXPO  = pss_pkg::EXPO_CYCLES;
	localparam int          XMIT  = pss_pkg::XMIT_CYCLES;
	localparam logic [15:0] BASEV = 16'h00b5;
	logic        clk_sys_i = 1'b0;
	logic        resetn_i  = 1'b0;
	logic [3:0]  addr_i    = 4'h0;
	logic [31:0] wdata_i   = 32'h0;
	logic        wr_i      = 1'b0;
	logic        rd_i      = 1'b0;
	logic        shot      = 1'b0;
	logic        rogue     = 1'b0;
	logic        ce        = 1'b1;
	logic [31:0] rdata_o;
	logic        trig_i;
	logic        waiting_o;
	logic        expose_o;
	logic        xmit_o;
	logic        irq_o;
	logic [15:0] active_param_o;
	logic [5:0]  active_index_o;
	logic [31:0] v;
	int          n_errors = 0;
	int          n_checks = 0;
	int          e_run = 0, x_run = 0, w_run = 0, e_len = 0, x_len = 0, w_len = 0, n_frames = 0;
	int          f0;

	always #10 clk_sys_i = ~clk_sys_i;

	pss_seq_top #(.LOADN(LOADN), .EXPO(EXPO), .XMIT(XMIT)) DUT (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trig_i(trig_i),
		.waiting_o(waiting_o), .active_param_o(active_param_o),
		.active_index_o(active_index_o), .expose_o(expose_o), .xmit_o(xmit_o), .irq_o(irq_o)
	);

	pss_trig_source trig_src (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .waiting_i(waiting_o),
		.shot_i(shot), .rogue_i(rogue), .trig_o(trig_i)
	);

	// lengths of the last exposure, transmission and non-waiting stretch
	always @(posedge clk_sys_i)
	begin
		e_run <= expose_o ? e_run + 1 : 0;
		x_run <= xmit_o ? x_run + 1 : 0;
		w_run <= waiting_o ? 0 : w_run + 1;
		if (!expose_o && e_run != 0)
			e_len <= e_run;
		if (!xmit_o && x_run != 0)
			x_len <= x_run;
		if (waiting_o && w_run != 0)
			w_len <= w_run;
		if (expose_o && e_run == 0)
			n_frames <= n_frames + 1;
	end

	function automatic logic [15:0] setv(input int i);
		return 16'h0a00 + 16'(i);
	endfunction : setv

	task automatic end_of_test;
		if (n_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_sys_i);
		wr_i    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_sys_i);
		rd_i   <= 1'b0;
		#1;
		d = rdata_o;
	endtask : rd

	// sel 0 watches waiting_o, sel 1 watches expose_o
	task automatic wait_on(input int sel, input logic lvl);
		for (int i = 0; i < 200; i++)
		begin
			@(posedge clk_sys_i);
			#1;
			if ((sel == 0 ? waiting_o : expose_o) === lvl)
				return;
		end
		chk(32'h0, 32'h1, "wait timed out");
		end_of_test();
	endtask : wait_on

	task automatic frame_go(input logic [15:0] pv, input logic [5:0] ix);
		@(posedge clk_sys_i);
		shot <= 1'b1;
		@(posedge clk_sys_i);
		shot <= 1'b0;
		wait_on(1, 1'b1);
		chk(32'(active_param_o), 32'(pv), "frame param");
		chk(32'(active_index_o), 32'(ix), "frame index");
	endtask : frame_go

	// a deferred load may follow the frame with a one-cycle waiting blip, so allow for it
	task automatic settle(input logic [15:0] pv, input logic [5:0] ix);
		wait_on(0, 1'b1);
		repeat (LOADN + 4) @(posedge clk_sys_i);
		#1;
		chk(32'(waiting_o), 32'h1, "waiting after load");
		chk(32'(active_param_o), 32'(pv), "active param");
		chk(32'(active_index_o), 32'(ix), "active index");
		rd(pss_pkg::REG_ACTIVE, v);
		chk(v, 32'(pv), "active readback");
	endtask : settle

	task automatic lens;
		chk(32'(e_len), 32'(EXPO), "expose length");
		chk(32'(x_len), 32'(XMIT), "xmit length");
	endtask : lens

	initial
	begin
		repeat (16) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		rd(pss_pkg::REG_TOTAL, v);
		chk(v, 32'(pss_pkg::TOTAL_RST), "total reset");
		rd(pss_pkg::REG_IRQ_MASK, v);
		chk(v, 32'(pss_pkg::MASK_RST), "mask reset");
		rd(4'ha, v);
		chk(v, 32'h0, "unmapped read");
		// a low clock enable must swallow a write completely
		@(posedge clk_sys_i);
		ce <= 1'b0;
		wr(pss_pkg::REG_TOTAL, 32'h2);
		ce <= 1'b1;
		rd(pss_pkg::REG_TOTAL, v);
		chk(v, 32'(pss_pkg::TOTAL_RST), "write while frozen");
		// a count above the set store falls back to one set
		wr(pss_pkg::REG_TOTAL, 32'h41);
		rd(pss_pkg::REG_TOTAL, v);
		chk(v, 32'h1, "total clamp");
		wr(pss_pkg::REG_TOTAL, 32'h3);
		for (int i = 0; i < 3; i++)
		begin
			wr(pss_pkg::REG_SET_IDX, 32'(i));
			wr(pss_pkg::REG_SET_DATA, 32'(setv(i)));
		end
		wr(pss_pkg::REG_BASE, 32'(BASEV));
		wr(pss_pkg::REG_CMD, 32'h1);
		repeat (8) @(posedge clk_sys_i);
		#1;
		chk(32'(active_param_o), 32'(BASEV), "step while off");
		wr(pss_pkg::REG_IRQ_MASK, 32'hf);
		wr(pss_pkg::REG_CTRL, 32'h1);
		settle(setv(0), 6'h0);
		chk(32'(w_len), 32'(LOADN), "load gap");
		chk(32'(irq_o), 32'h1, "irq on load");
		rd(pss_pkg::REG_STATUS, v);
		chk(v & 32'h3f3f, 32'h3, "status idle");
		rd(pss_pkg::REG_CTRL, v);
		chk(v, 32'h1, "ctrl readback");
		wr(pss_pkg::REG_IRQ_STAT, 32'hf);
		rd(pss_pkg::REG_IRQ_STAT, v);
		chk(v & 32'h1, 32'h0, "load flag cleared");
		chk(32'(irq_o), 32'h0, "irq cleared");
		// step sent mid-frame stays pending until the frame is over
		frame_go(setv(0), 6'h0);
		wr(pss_pkg::REG_CMD, 32'h1);
		rd(pss_pkg::REG_STATUS, v);
		chk(v & 32'h14, 32'h14, "step pending");
		chk(32'(active_param_o), 32'(setv(0)), "set held");
		settle(setv(1), 6'h1);
		lens();
		// a trigger during a load must not start a frame
		wr(pss_pkg::REG_IRQ_STAT, 32'hf);
		f0 = n_frames;
		wr(pss_pkg::REG_CMD, 32'h1);
		@(posedge clk_sys_i);
		rogue <= 1'b1;
		@(posedge clk_sys_i);
		rogue <= 1'b0;
		settle(setv(2), 6'h2);
		chk(32'(n_frames), 32'(f0), "frame from ignored trigger");
		rd(pss_pkg::REG_IRQ_STAT, v);
		chk(v & 32'h4, 32'h4, "ignored trigger flag");
		// wrap past the last set, with its event masked
		wr(pss_pkg::REG_IRQ_MASK, 32'h0);
		wr(pss_pkg::REG_IRQ_STAT, 32'hf);
		wr(pss_pkg::REG_CMD, 32'h1);
		settle(setv(0), 6'h0);
		chk(32'(irq_o), 32'h0, "masked irq");
		rd(pss_pkg::REG_IRQ_STAT, v);
		chk(v & 32'h9, 32'h9, "wrap flag");
		wr(pss_pkg::REG_IRQ_MASK, 32'h8);
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk(32'(irq_o), 32'h1, "unmasked irq");
		wr(pss_pkg::REG_CMD, 32'h1);
		settle(setv(1), 6'h1);
		// rewind sent mid-frame
		frame_go(setv(1), 6'h1);
		wr(pss_pkg::REG_CMD, 32'h2);
		#1;
		chk(32'(active_param_o), 32'(setv(1)), "set held on rewind");
		settle(setv(0), 6'h0);
		lens();
		// disable during exposure: the frame completes, then the base value returns
		frame_go(setv(0), 6'h0);
		wr(pss_pkg::REG_CTRL, 32'h0);
		#1;
		chk(32'(expose_o), 32'h1, "frame continues");
		settle(BASEV, 6'h0);
		lens();
		rd(pss_pkg::REG_STATUS, v);
		chk(v & 32'h2, 32'h0, "cycling stopped");
		rd(pss_pkg::REG_IRQ_STAT, v);
		chk(v & 32'h2, 32'h2, "frame done flag");
		rd(pss_pkg::REG_BASE, v);
		chk(v, 32'(BASEV), "base readback");
		rd(pss_pkg::REG_CTRL, v);
		chk(v, 32'h0, "ctrl cleared");
		end_of_test();
	end
endmodule : pss_seq_top_bench
